//--- hw/pps_pkg.sv
// Shared constants and types for the pulse program sequencer
package pps_pkg;

   // Wide program word layout
   localparam int PPS_WORD_W = 80;
   localparam int PPS_PAT_W = 24;
   localparam int PPS_DATA_W = 20;
   localparam int PPS_OP_W = 4;
   localparam int PPS_DLY_W = 32;
   localparam int PPS_ADDR_W = 12;
   localparam int PPS_DEPTH = 4096;
   localparam int PPS_HI_W = PPS_WORD_W - 64;

   // Timing
   localparam logic [32:0] PPS_OVERHEAD = 33'h000000003;
   localparam int PPS_MIN_CYCLES = 5;

   // Opcodes
   localparam logic [3:0] PPS_OP_CONT = 4'h0;
   localparam logic [3:0] PPS_OP_STOP = 4'h1;
   localparam logic [3:0] PPS_OP_LOOP = 4'h2;
   localparam logic [3:0] PPS_OP_ENDLOOP = 4'h3;
   localparam logic [3:0] PPS_OP_CALL = 4'h4;
   localparam logic [3:0] PPS_OP_RET = 4'h5;
   localparam logic [3:0] PPS_OP_BRANCH = 4'h6;
   localparam logic [3:0] PPS_OP_LDELAY = 4'h7;
   localparam logic [3:0] PPS_OP_WAIT = 4'h8;

   // Register byte offsets
   localparam logic [7:0] PPS_REG_CTRL = 8'h00;
   localparam logic [7:0] PPS_REG_STATUS = 8'h04;
   localparam logic [7:0] PPS_REG_LOAD_ADDR = 8'h08;
   localparam logic [7:0] PPS_REG_WORD_LO = 8'h0c;
   localparam logic [7:0] PPS_REG_WORD_MID = 8'h10;
   localparam logic [7:0] PPS_REG_WORD_HI = 8'h14;
   localparam logic [7:0] PPS_REG_PC = 8'h18;

   // Control and status bit positions
   localparam int PPS_CTRL_START = 0;
   localparam int PPS_CTRL_STOP = 1;
   localparam int PPS_CTRL_REWIND = 2;
   localparam int PPS_CTRL_TRIG = 3;
   localparam int PPS_STAT_IDLE = 0;
   localparam int PPS_STAT_ARMED = 1;
   localparam int PPS_STAT_RUN = 2;
   localparam int PPS_STAT_WAIT = 3;

   typedef struct packed {
      logic [PPS_PAT_W-1:0] pattern;
      logic [PPS_DATA_W-1:0] data;
      logic [PPS_OP_W-1:0] opcode;
      logic [PPS_DLY_W-1:0] delay;
   } pps_word_t;

   typedef enum logic [2:0] {
      PPS_IDLE = 3'b001,
      PPS_RUN = 3'b010,
      PPS_WAIT = 3'b100
   } pps_state_t;

   typedef struct packed {
      pps_state_t st;
      logic primed;
      logic pend;
      logic armed;
      logic loop_on;
      logic running;
      logic waiting;
      logic trig_q;
      logic ack;
      logic [PPS_ADDR_W-1:0] pc;
      logic [PPS_ADDR_W-1:0] fetch;
      logic [PPS_ADDR_W-1:0] ret;
      logic [PPS_ADDR_W-1:0] load_addr;
      logic [PPS_DATA_W-1:0] loop_cnt;
      logic [PPS_PAT_W-1:0] pattern;
      logic [31:0] rdata;
      logic [31:0] lo;
      logic [31:0] mid;
   } pps_main_t;

   localparam pps_main_t PPS_MAIN_RST = '{st: PPS_IDLE, armed: 1'b1, default: '0};

   typedef struct packed {
      logic [32:0] cnt;
      logic [32:0] dur;
      logic [PPS_DATA_W-1:0] rep;
   } pps_tmr_t;

   localparam pps_tmr_t PPS_TMR_RST = '0;

endpackage : pps_pkg

//--- hw/pps_prog_mem.sv
// Program memory of wide program words, one write and one registered read port
`timescale 1ns/1ps
module pps_prog_mem
   import pps_pkg::*;
(
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [PPS_ADDR_W-1:0] waddr_i,
   input wire logic [PPS_WORD_W-1:0] wdata_i,
   input wire logic [PPS_ADDR_W-1:0] raddr_i,
   output logic [PPS_WORD_W-1:0] rdata_o
);

   logic [PPS_WORD_W-1:0] mem [PPS_DEPTH];

   // No reset on the array; read data is one cycle behind the address
   always_ff @(posedge clk_i) begin // see RULE3
      if (we_i) begin
         mem[waddr_i] <= wdata_i;
      end
      rdata_o <= mem[raddr_i];
   end

endmodule : pps_prog_mem

//--- hw/pps_dur_timer.sv
// Instruction duration counter with repeat multiplier
`timescale 1ns/1ps
module pps_dur_timer
   import pps_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic load_i,
   input wire logic [32:0] dur_i,
   input wire logic [PPS_DATA_W-1:0] reps_i,
   output logic done_o
);

   pps_tmr_t s;
   pps_tmr_t next_s;

   // Last cycle of the instruction: count spent and no repeats left
   assign done_o = (s.cnt == 33'h0) && (s.rep <= 20'h00001);

   always_comb begin
      next_s = s;
      if (load_i) begin
         next_s.cnt = dur_i - 33'h1;
         next_s.dur = dur_i;
         next_s.rep = reps_i;
      end else if (s.cnt != 33'h0) begin
         next_s.cnt = s.cnt - 33'h1;
      end else if (s.rep > 20'h00001) begin
         next_s.cnt = s.dur - 33'h1; // see RULE14
         next_s.rep = s.rep - 20'h00001;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= PPS_TMR_RST;
      end else begin
         s <= next_s;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_load_min;
      load_i && dur_i == 33'h5 && reps_i <= 20'h00001;
   endsequence

   sequence s_run_min;
      !done_o [*4];
   endsequence

   sequence s_no_reload;
      !load_i [*4];
   endsequence

   // A trigger may reload early on a wait word, so the end is only checked without reload
   a_min_dur_exact: assert property (s_load_min ##1 s_no_reload |=> done_o) // see RULE18
      else $error("five cycle duration not honoured");

   a_min_dur_hold: assert property (s_load_min |=> s_run_min) // see RULE4
      else $error("instruction ended before five cycles");

endmodule : pps_dur_timer

//--- hw/pps_seq.sv
// Pulse program sequencer top: bus slave, instruction decode and flow control
// Notes on behaviour
// RULE1 - Fetch and execute 80-bit program words, each a full fixed-format instruction.
// RULE2 - Word fields: 24-bit pattern, 20-bit data, 4-bit opcode, 32-bit delay.
// RULE3 - Program memory holds 4096 words.
// RULE4 - Shortest instruction lasts five core clock cycles with internal memory.
// RULE5 - Output bits 0..23 follow the running instruction's pattern field.
// RULE6 - Data field meaning depends on opcode; unused for continue, stop, return, wait.
// RULE7 - Opcode 0 moves to the next word when the duration ends.
// RULE8 - Opcode 1 halts execution and leaves the sequencer idle.
// RULE9 - Opcode 2 loads loop counter from data, then continues; count at least 1.
// RULE10 - Opcode 3 decrements loop counter and jumps to loop start in data.
// RULE11 - Opcode 4 saves return point and jumps to subroutine address in data.
// RULE12 - Opcode 5 resumes right after the most recent call.
// RULE13 - Opcode 6 jumps unconditionally to the address in data.
// RULE14 - Opcode 7 lasts delay duration times data multiplier, multiplier at least 2.
// RULE15 - Opcode 8 suspends until a software or hardware trigger, then continues.
// RULE16 - Loader puts a longer than minimum instruction before every wait.
// RULE17 - Loader keeps delay count within its allowed minimum and maximum.
// RULE18 - Every instruction lasts its delay count plus three cycles; the code holds a wait word until its trigger and repeats opcode 7 data times.
// RULE19 - Running is high while executing or waiting; waiting only while suspended.
// RULE20 - A trigger while idle after a rewind restarts from the first word.
// RULE21 - Rewind input returns to program start; resume by start or trigger.
// RULE22 - Exhausted loop counter makes end-of-loop fall through to the next word.
// RULE23 - A new pattern appears in the cycle its duration count begins.
`timescale 1ns/1ps
module pps_seq
   import pps_pkg::*;
(
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic external_resume_input,
   input wire logic external_rewind_input,
   output logic [PPS_PAT_W-1:0] pattern_o,
   output logic running_o,
   output logic waiting_o,
   output logic rewound_o
);

   pps_main_t s;
   pps_main_t next_s;

   logic [PPS_WORD_W-1:0] mem_q;
   logic [PPS_WORD_W-1:0] mem_wdata;
   logic mem_we;
   logic t_done;
   logic t_load;
   logic [32:0] t_dur;
   logic [PPS_DATA_W-1:0] t_reps;
   logic [31:0] wmask;
   logic [31:0] wmerge;
   pps_word_t w;

   // Byte enables widened to a bit mask
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_mask
         assign wmask[8*gi +: 8] = {8{wb_sel_i[gi]}};
      end
   endgenerate

   assign wmerge = wb_dat_i & wmask;
   assign w = pps_word_t'(mem_q); // see RULE1 // see RULE2

   pps_prog_mem i_pps_prog_mem (
      .clk_i(clk_i),
      .we_i(mem_we),
      .waddr_i(s.load_addr),
      .wdata_i(mem_wdata),
      .raddr_i(s.fetch),
      .rdata_o(mem_q)
   );

   pps_dur_timer i_pps_dur_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .load_i(t_load),
      .dur_i(t_dur),
      .reps_i(t_reps),
      .done_o(t_done)
   );

   always_comb begin
      logic req;
      logic wr;
      logic take;
      logic trig;
      logic sw_start;
      logic sw_stop;
      logic sw_rewind;
      logic sw_trig;
      logic is_idle;
      req = 1'b0;
      wr = 1'b0;
      take = 1'b0;
      trig = 1'b0;
      sw_start = 1'b0;
      sw_stop = 1'b0;
      sw_rewind = 1'b0;
      sw_trig = 1'b0;
      is_idle = 1'b0;
      next_s = s;
      mem_we = 1'b0;
      mem_wdata = '0;

      // Bus slave: ack one cycle after the request, dropped the cycle after
      req = wb_cyc_i && wb_stb_i && !s.ack;
      wr = wb_cyc_i && wb_stb_i && wb_we_i && s.ack;
      next_s.ack = req;
      next_s.rdata = 32'h00000000;
      if (req && !wb_we_i) begin
         case (wb_adr_i)
            PPS_REG_STATUS: begin
               next_s.rdata[PPS_STAT_IDLE] = (s.st == PPS_IDLE);
               next_s.rdata[PPS_STAT_ARMED] = s.armed;
               next_s.rdata[PPS_STAT_RUN] = s.running;
               next_s.rdata[PPS_STAT_WAIT] = s.waiting;
            end
            PPS_REG_LOAD_ADDR: next_s.rdata[PPS_ADDR_W-1:0] = s.load_addr;
            PPS_REG_WORD_LO: next_s.rdata = s.lo;
            PPS_REG_WORD_MID: next_s.rdata = s.mid;
            PPS_REG_PC: next_s.rdata[PPS_ADDR_W-1:0] = s.pc;
            default: next_s.rdata = 32'h00000000;
         endcase
      end

      // Writes take effect at the edge where ack is seen
      if (wr) begin
         case (wb_adr_i)
            PPS_REG_CTRL: begin
               sw_start = wmerge[PPS_CTRL_START];
               sw_stop = wmerge[PPS_CTRL_STOP];
               sw_rewind = wmerge[PPS_CTRL_REWIND];
               sw_trig = wmerge[PPS_CTRL_TRIG];
            end
            PPS_REG_LOAD_ADDR: begin
               next_s.load_addr = (s.load_addr & ~wmask[PPS_ADDR_W-1:0])
                  | wmerge[PPS_ADDR_W-1:0];
            end
            PPS_REG_WORD_LO: next_s.lo = (s.lo & ~wmask) | wmerge;
            PPS_REG_WORD_MID: next_s.mid = (s.mid & ~wmask) | wmerge;
            PPS_REG_WORD_HI: begin
               // Commits a whole word and steps the load address
               mem_we = 1'b1;
               mem_wdata = {wmerge[PPS_HI_W-1:0], s.mid, s.lo};
               next_s.load_addr = s.load_addr + 12'h001;
            end
            default: next_s.lo = s.lo;
         endcase
      end

      // Trigger on a rising resume level or a software strobe
      next_s.trig_q = external_resume_input;
      trig = (external_resume_input && !s.trig_q) || sw_trig;
      is_idle = (s.st == PPS_IDLE);

      case (s.st)
         PPS_IDLE: begin
            // One idle cycle lets word 0 settle on the read port
            next_s.primed = 1'b1;
            if (s.pend && s.primed) begin
               take = 1'b1;
               next_s.pend = 1'b0;
            end
         end
         PPS_RUN: take = t_done; // see RULE7
         PPS_WAIT: take = trig; // see RULE15
         default: next_s.st = PPS_IDLE;
      endcase

      // Late start or trigger is held rather than lost
      if (sw_start || (trig && s.armed && is_idle)) begin // see RULE20
         next_s.pend = 1'b1;
      end

      t_load = take;
      t_dur = {1'b0, w.delay} + PPS_OVERHEAD; // see RULE18
      t_reps = (w.opcode == PPS_OP_LDELAY) ? w.data : 20'h00001; // see RULE14

      if (take) begin
         next_s.pattern = w.pattern; // see RULE5 // see RULE23
         next_s.pc = s.fetch;
         next_s.st = PPS_RUN;
         next_s.running = 1'b1; // see RULE19
         next_s.waiting = 1'b0;
         next_s.armed = 1'b0;
         next_s.fetch = s.fetch + 12'h001;
         // Data field only read where the opcode gives it a meaning
         case (w.opcode) // see RULE6
            PPS_OP_STOP: begin
               next_s.st = PPS_IDLE; // see RULE8
               next_s.running = 1'b0;
               next_s.fetch = '0;
               next_s.primed = 1'b0;
            end
            PPS_OP_LOOP: begin
               // Re-entry from its own end-of-loop must not reload the count
               if (!s.loop_on) begin // see RULE9
                  next_s.loop_cnt = w.data;
                  next_s.loop_on = 1'b1;
               end
            end
            PPS_OP_ENDLOOP: begin
               if (s.loop_cnt > 20'h00001) begin // see RULE10
                  next_s.loop_cnt = s.loop_cnt - 20'h00001;
                  next_s.fetch = w.data[PPS_ADDR_W-1:0];
               end else begin
                  next_s.loop_on = 1'b0; // see RULE22
               end
            end
            PPS_OP_CALL: begin
               next_s.ret = s.fetch + 12'h001; // see RULE11
               next_s.fetch = w.data[PPS_ADDR_W-1:0];
            end
            PPS_OP_RET: next_s.fetch = s.ret; // see RULE12
            PPS_OP_BRANCH: next_s.fetch = w.data[PPS_ADDR_W-1:0]; // see RULE13
            PPS_OP_WAIT: begin
               next_s.st = PPS_WAIT;
               next_s.waiting = 1'b1; // see RULE19
            end
            default: next_s.fetch = s.fetch + 12'h001;
         endcase
      end

      // Stop and rewind override any instruction taken this cycle
      if (sw_stop) begin
         next_s.st = PPS_IDLE;
         next_s.running = 1'b0;
         next_s.waiting = 1'b0;
         next_s.fetch = '0;
         next_s.primed = 1'b0;
         next_s.pend = 1'b0;
      end
      if (external_rewind_input || sw_rewind) begin // see RULE21
         next_s.st = PPS_IDLE;
         next_s.running = 1'b0;
         next_s.waiting = 1'b0;
         next_s.fetch = '0;
         next_s.pc = '0;
         next_s.primed = 1'b0;
         next_s.pend = 1'b0;
         next_s.armed = 1'b1;
         next_s.loop_on = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s <= PPS_MAIN_RST;
      end else begin
         s <= next_s;
      end
   end

   assign wb_dat_o = s.rdata;
   assign wb_ack_o = s.ack;
   assign pattern_o = s.pattern;
   assign running_o = s.running;
   assign waiting_o = s.waiting;
   assign rewound_o = s.armed;

   // Helper: cycles since the last instruction was taken
   logic [7:0] icnt;
   logic seen;
   always_ff @(posedge clk_i) begin
      if (rst_i || t_load) begin
         icnt <= 8'h00;
         seen <= !rst_i && t_load;
      end else if (icnt != 8'hff) begin
         icnt <= icnt + 8'h01;
      end
   end

   localparam int MINM1 = PPS_MIN_CYCLES - 1;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held two cycles");

   a_min_instr_time: assert property ( // see RULE4
      (t_load && seen && s.st == PPS_RUN) |-> icnt >= 8'(MINM1))
      else $error("instruction shorter than minimum");

   a_pattern_follows: assert property ( // see RULE5
      t_load |=> pattern_o == $past(w.pattern))
      else $error("pattern not taken from new word");

   // Stop word, rewind, or a control write setting the stop or rewind bit in the take cycle leave the sequencer idle
   a_take_runs: assert property ( // see RULE19
      (t_load && w.opcode != PPS_OP_STOP && !external_rewind_input
       && !(wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_adr_i == PPS_REG_CTRL))
      |=> running_o)
      else $error("taken word not running");

   a_stop_idles: assert property ( // see RULE8
      (t_load && w.opcode == PPS_OP_STOP && !external_rewind_input)
      |=> !running_o && s.st == PPS_IDLE)
      else $error("stop did not idle");

   a_wait_running: assert property (waiting_o |-> running_o) // see RULE19
      else $error("waiting without running");

   a_branch_target: assert property ( // see RULE13
      (t_load && w.opcode == PPS_OP_BRANCH && !external_rewind_input)
      |=> s.fetch == $past(w.data[PPS_ADDR_W-1:0]))
      else $error("branch target wrong");

   a_call_return: assert property ( // see RULE11
      (t_load && w.opcode == PPS_OP_CALL && !external_rewind_input)
      |=> s.ret == $past(s.fetch) + 12'h001)
      else $error("return point wrong");

   a_continue_next: assert property ( // see RULE7
      (t_load && w.opcode == PPS_OP_CONT && !external_rewind_input)
      |=> s.fetch == $past(s.fetch) + 12'h001)
      else $error("continue not sequential");

   a_rewind_start: assert property ( // see RULE21
      external_rewind_input |=> !running_o && s.pc == '0 ##1 s.fetch == '0)
      else $error("rewind did not return to start");

   a_loop_fallthru: assert property ( // see RULE22
      (t_load && w.opcode == PPS_OP_ENDLOOP && s.loop_cnt <= 20'h00001
       && !external_rewind_input) |=> !s.loop_on)
      else $error("exhausted loop did not fall through");

endmodule : pps_seq

//--- tb/pps_inst_model.sv
// Receiver model: logs every output pattern change with its cycle number
`timescale 1ns/1ps
module pps_inst_model
   import pps_pkg::*;
(
   input wire logic clk_i,
   input wire logic clr_i,
   input wire logic [PPS_PAT_W-1:0] pattern_i
);
   int cyc = 0;
   int chg_cyc[$];
   logic [PPS_PAT_W-1:0] chg_pat[$];
   logic [PPS_PAT_W-1:0] prev = '0;
   // Instruments latch all 24 bits on each change
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      prev <= pattern_i;
      if (clr_i) begin
         chg_cyc.delete();
         chg_pat.delete();
      end else if (pattern_i !== prev) begin
         chg_cyc.push_back(cyc);
         chg_pat.push_back(pattern_i);
      end
   end
endmodule : pps_inst_model

//--- tb/tb_top.sv
// Self-checking bench for the pulse program sequencer
`timescale 1ns/1ps
module tb_top;
   import pps_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = '0;
   logic [3:0] sel = '0;
   logic [31:0] dat = '0;
   logic [31:0] rd;
   logic [31:0] dat_o;
   logic ack;
   logic resume = 1'b0;
   logic rewind = 1'b0;
   logic clr = 1'b1;
   logic [PPS_PAT_W-1:0] pat_o;
   logic run;
   logic wt;
   logic rew;
   logic [79:0] prog[10];
   int error_cnt = 0;
   int total_checks = 0;

   pps_seq i_pps_seq (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .external_resume_input(resume), .external_rewind_input(rewind),
      .pattern_o(pat_o), .running_o(run), .waiting_o(wt), .rewound_o(rew));
   pps_inst_model i_pps_inst_model (.clk_i(clk_i), .clr_i(clr), .pattern_i(pat_o));

   initial forever #2 clk_i = ~clk_i;

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   // Classic cycle: hold request until ack is seen, release on that edge
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      sel <= 4'hf;
      do begin
         @(posedge clk_i);
         n++;
         if (n > 20) begin
            error_cnt++;
            tally_and_finish();
         end
      end while (ack !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wb(1'b1, a, d);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string nm);
      wb(1'b0, a, 32'h0);
      chk(nm, rd, exp);
   endtask : rdc

   // Bounded poll of running (ws=0) or waiting (ws=1), sampled mid-cycle
   task automatic wait_sig(input bit ws, input logic v, input int lim);
      int n;
      n = 0;
      while ((ws ? wt : run) !== v) begin
         @(negedge clk_i);
         n++;
         if (n > lim) begin
            error_cnt++;
            $display("CHECK FAILED wait expected %h seen timeout", v);
            tally_and_finish();
         end
      end
   endtask : wait_sig

   task automatic pulse(input bit r);
      @(posedge clk_i);
      if (r) rewind <= 1'b1;
      else resume <= 1'b1;
      @(posedge clk_i);
      rewind <= 1'b0;
      resume <= 1'b0;
   endtask : pulse

   function automatic logic [23:0] pat(input int k);
      return {k[3:0], 20'ha5c3e};
   endfunction : pat

   function automatic logic [79:0] mk(input int k, input logic [3:0] op, input int dt,
      input int d);
      return {pat(k), dt[19:0], op, d[31:0]};
   endfunction : mk

   task automatic t_load();
      prog[0] = mk(1, PPS_OP_CONT, 'hfffff, 2);
      prog[1] = mk(2, PPS_OP_LOOP, 2, 3);
      prog[2] = mk(3, PPS_OP_ENDLOOP, 1, 2);
      prog[3] = mk(4, PPS_OP_CALL, 6, 2);
      prog[4] = mk(5, PPS_OP_LDELAY, 3, 2);
      prog[5] = mk(6, PPS_OP_BRANCH, 7, 2);
      prog[6] = mk(7, PPS_OP_RET, 0, 4);
      prog[7] = mk(8, PPS_OP_CONT, 0, 4);
      prog[8] = mk(9, PPS_OP_WAIT, 'hfffff, 2);
      prog[9] = mk(10, PPS_OP_STOP, 0, 2);
      wr(PPS_REG_LOAD_ADDR, 32'hfff);
      wr(PPS_REG_WORD_LO, 32'h2);
      wr(PPS_REG_WORD_MID, 32'h1);
      wr(PPS_REG_WORD_HI, 32'h0);
      rdc(PPS_REG_LOAD_ADDR, 32'h0, "load_addr wrap");
      wr(PPS_REG_LOAD_ADDR, 32'h0);
      for (int i = 0; i < 10; i++) begin
         wr(PPS_REG_WORD_LO, prog[i][31:0]);
         wr(PPS_REG_WORD_MID, prog[i][63:32]);
         wr(PPS_REG_WORD_HI, {16'h0, prog[i][79:64]});
      end
      rdc(PPS_REG_LOAD_ADDR, 32'ha, "load_addr count");
      $display("test load done");
   endtask : t_load

   // Whole program: loop twice, call, long delay, branch, wait, stop
   task automatic t_flow();
      int seq[12] = '{1, 2, 3, 2, 3, 4, 7, 5, 6, 8, 9, 10};
      int dur[10] = '{5, 6, 5, 6, 5, 5, 7, 15, 5, 7};
      @(posedge clk_i);
      clr <= 1'b0;
      wr(PPS_REG_CTRL, 32'h1);
      rdc(PPS_REG_STATUS, 32'h4, "status running");
      wait_sig(1'b1, 1'b1, 300);
      chk("running in wait", run, 1'b1);
      chk("pattern in wait", pat_o, pat(9));
      rdc(PPS_REG_STATUS, 32'hc, "status waiting");
      rdc(PPS_REG_PC, 32'h8, "pc in wait");
      pulse(1'b0);
      wait_sig(1'b0, 1'b0, 20);
      // Receiver logs a change one edge after it shows
      repeat (2) @(negedge clk_i);
      chk("change count", i_pps_inst_model.chg_pat.size(), 12);
      for (int i = 0; i < 12; i++) begin
         chk("pattern", i_pps_inst_model.chg_pat[i], pat(seq[i]));
      end
      for (int i = 0; i < 10; i++) begin
         chk("duration", i_pps_inst_model.chg_cyc[i + 1] - i_pps_inst_model.chg_cyc[i],
            dur[i]);
      end
      chk("waiting after stop", wt, 1'b0);
      chk("stop pattern", pat_o, pat(10));
      $display("test flow done");
   endtask : t_flow

   task automatic t_restart();
      pulse(1'b0);
      repeat (10) @(posedge clk_i);
      chk("trigger after stop", run, 1'b0);
      pulse(1'b1);
      @(negedge clk_i);
      chk("rewound", rew, 1'b1);
      pulse(1'b0);
      wait_sig(1'b0, 1'b1, 20);
      chk("trigger restart", pat_o, pat(1));
      repeat (8) @(posedge clk_i);
      pulse(1'b1);
      wait_sig(1'b0, 1'b0, 5);
      chk("rewound mid run", rew, 1'b1);
      wr(PPS_REG_CTRL, 32'h1);
      wait_sig(1'b0, 1'b1, 20);
      chk("start restart", pat_o, pat(1));
      wr(PPS_REG_CTRL, 32'h2);
      wait_sig(1'b0, 1'b0, 10);
      rdc(PPS_REG_STATUS, 32'h1, "status stopped");
      rdc(8'h1c, 32'h0, "unmapped read");
      rdc(PPS_REG_CTRL, 32'h0, "ctrl read");
      $display("test restart done");
   endtask : t_restart

   initial begin
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      t_load();
      t_flow();
      t_restart();
      tally_and_finish();
   end
endmodule : tb_top
